// File: rtl/peripheral_disable_regs_two_three.sv
// Peripheral disable registers two and three with clock gate and reset hold controls.
`timescale 1ns/1ps
`include "pmd_cfg.svh"
module peripheral_disable_regs_two_three (
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 nrst,
  // Register port.
  input  wire pmd_pkg::bus_req_type bus_req,
  output logic [15:0]               rdata,
  // Peripheral controls.
  output pmd_pkg::periph_off_type   periph_off,
  output logic [9:0]                periph_clk_en,
  output logic [9:0]                periph_rst_n
);

  logic [15:0] cc_q;
  logic [15:0] ci_q;
  logic [15:0] rdata_q;
  logic [9:0]  off_vec;

  // Register two keeps only its implemented bits.
  // masked store
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cc_q <= `DISABLE_RESET;
    else if (bus_req.wr && bus_req.addr == `CC_DISABLE_ADDR)
      cc_q <= bus_req.wdata & `CC_IMPL_MASK;
  end

  // Register three keeps only the comparator and I2C bits.
  // masked store
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ci_q <= `DISABLE_RESET;
    else if (bus_req.wr && bus_req.addr == `CI_DISABLE_ADDR)
      ci_q <= bus_req.wdata & `CI_IMPL_MASK;
  end

  // Read data stands in the cycle after the strobe only; unmapped reads give zero.
  // read back
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= 16'h0000;
    else if (bus_req.rd && bus_req.addr == `CC_DISABLE_ADDR)
      rdata_q <= cc_q;
    else if (bus_req.rd && bus_req.addr == `CI_DISABLE_ADDR)
      rdata_q <= ci_q;
    else
      rdata_q <= 16'h0000;
  end
  assign rdata = rdata_q;

  // Field extraction; units run four down to one in the bit order.
  // field map
  assign periph_off.capture_off          = cc_q[`CC_CAPTURE_LSB +: 4];
  assign periph_off.compare_off          = cc_q[`CC_COMPARE_LSB +: 4];
  assign periph_off.comparator_group_off = ci_q[`CI_COMPARATOR_BIT];
  assign periph_off.second_i2c_off       = ci_q[`CI_I2C2_BIT];
  assign off_vec = periph_off;

  // Gating is straight from flip-flops so a disabled unit never sees a glitchy enable.
  // gate and hold
  genvar g;
  generate
    for (g = 0; g < 10; g++)
    begin : gen_gate
      assign periph_clk_en[g] = ~off_vec[g];
      assign periph_rst_n[g]  = ~off_vec[g];
    end
  endgenerate

  // Reserved positions have no storage behind them, so a one seen here is a mask fault.
  // reserved stay zero
  property p_cc_unimpl;
    @(posedge clock) disable iff (!nrst) (cc_q & ~`CC_IMPL_MASK) == 16'h0000;
  endproperty
  a_cc_unimpl: assert property (p_cc_unimpl) else $error("register two reserved bit set");

  // Register three has only two live positions out of sixteen.
  // reserved stay zero
  property p_ci_unimpl;
    @(posedge clock) disable iff (!nrst) (ci_q & ~`CI_IMPL_MASK) == 16'h0000;
  endproperty
  a_ci_unimpl: assert property (p_ci_unimpl) else $error("register three reserved bit set");

  // A write to register two shows its capture bits from the next cycle on.
  // capture bits stored
  property p_cc_write;
    @(posedge clock) disable iff (!nrst)
      bus_req.wr && bus_req.addr == `CC_DISABLE_ADDR |=> cc_q[11:8] == $past(bus_req.wdata[11:8]);
  endproperty
  a_cc_write: assert property (p_cc_write) else $error("capture bits not stored");

  // The compare bits reach the peripheral controls one cycle after the write.
  // compare bits stored
  property p_cc_cmp_write;
    @(posedge clock) disable iff (!nrst)
      bus_req.wr && bus_req.addr == `CC_DISABLE_ADDR
      |=> periph_off.compare_off == $past(bus_req.wdata[3:0]);
  endproperty
  a_cc_cmp_write: assert property (p_cc_cmp_write) else $error("compare bits not stored");

  // The comparator group control follows its bit of register three.
  // comparator bit stored
  property p_comp_write;
    @(posedge clock) disable iff (!nrst)
      bus_req.wr && bus_req.addr == `CI_DISABLE_ADDR
      |=> periph_off.comparator_group_off == $past(bus_req.wdata[10]);
  endproperty
  a_comp_write: assert property (p_comp_write) else $error("comparator bit not stored");

  // The second I2C unit control follows its bit of register three.
  // I2C bit stored
  property p_i2c_write;
    @(posedge clock) disable iff (!nrst)
      bus_req.wr && bus_req.addr == `CI_DISABLE_ADDR
      |=> periph_off.second_i2c_off == $past(bus_req.wdata[1]);
  endproperty
  a_i2c_write: assert property (p_i2c_write) else $error("i2c bit not stored");

  // A read of register three returns what it held when the strobe was taken.
  // read back three
  property p_readback;
    @(posedge clock) disable iff (!nrst)
      bus_req.rd && bus_req.addr == `CI_DISABLE_ADDR |=> rdata == $past(ci_q);
  endproperty
  a_readback: assert property (p_readback) else $error("read data mismatch");

  // A read of register two returns what it held when the strobe was taken.
  // read back two
  property p_cc_readback;
    @(posedge clock) disable iff (!nrst)
      bus_req.rd && bus_req.addr == `CC_DISABLE_ADDR |=> rdata == $past(cc_q);
  endproperty
  a_cc_readback: assert property (p_cc_readback) else $error("reg two read mismatch");

  // Reads outside the two registers return zero rather than a stale word.
  // unmapped reads zero
  property p_unmapped_read;
    @(posedge clock) disable iff (!nrst)
      bus_req.rd && bus_req.addr != `CC_DISABLE_ADDR && bus_req.addr != `CI_DISABLE_ADDR
      |=> rdata == 16'h0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // Writes outside the two registers leave both of them untouched.
  // unmapped writes ignored
  property p_unmapped_write;
    @(posedge clock) disable iff (!nrst)
      bus_req.wr && bus_req.addr != `CC_DISABLE_ADDR && bus_req.addr != `CI_DISABLE_ADDR
      |=> $stable(cc_q) && $stable(ci_q);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write landed");

  // Read data stand for one cycle only, so a stale word never looks like a second read.
  // one-cycle read data
  property p_rdata_idle;
    @(posedge clock) disable iff (!nrst) !bus_req.rd |=> rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data held too long");

  // Without a write strobe to it, register two keeps its last written value.
  // value kept
  property p_cc_hold;
    @(posedge clock) disable iff (!nrst)
      !(bus_req.wr && bus_req.addr == `CC_DISABLE_ADDR) |=> $stable(cc_q);
  endproperty
  a_cc_hold: assert property (p_cc_hold) else $error("register two changed without write");

  // Without a write strobe to it, register three keeps its last written value.
  // value kept
  property p_ci_hold;
    @(posedge clock) disable iff (!nrst)
      !(bus_req.wr && bus_req.addr == `CI_DISABLE_ADDR) |=> $stable(ci_q);
  endproperty
  a_ci_hold: assert property (p_ci_hold) else $error("register three changed without write");

  // Both registers come out of reset with every bit clear.
  // clear after reset
  property p_reset_clear;
    @(posedge clock) $rose(nrst) |-> cc_q == 16'h0000 && ci_q == 16'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("bits not clear after reset");

  // Just after reset every covered peripheral runs and the read port is quiet.
  // enabled after reset
  property p_reset_outputs;
    @(posedge clock) $rose(nrst)
      |-> rdata == 16'h0000 && periph_clk_en == 10'h3FF && periph_rst_n == 10'h3FF;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("not idle after reset");

  // The capture enables and the I2C hold follow their disable bits inverted.
  // gate and hold
  property p_gate;
    @(posedge clock) disable iff (!nrst)
      periph_clk_en[9:6] == ~cc_q[11:8] && periph_rst_n[0] == ~ci_q[1];
  endproperty
  a_gate: assert property (p_gate) else $error("gate does not follow disable bit");

  // The compare, comparator and I2C enables follow their disable bits inverted.
  // remaining gates
  property p_gate_rest;
    @(posedge clock) disable iff (!nrst)
      periph_clk_en[5:2] == ~cc_q[3:0] && periph_clk_en[1] == ~ci_q[10]
      && periph_clk_en[0] == ~ci_q[1];
  endproperty
  a_gate_rest: assert property (p_gate_rest) else $error("enable not following bit");

  // A unit held in reset must also have its clock stopped, and the other way round.
  // hold matches gate
  property p_hold_match;
    @(posedge clock) disable iff (!nrst) periph_rst_n == periph_clk_en;
  endproperty
  a_hold_match: assert property (p_hold_match) else $error("hold and gate differ");

endmodule : peripheral_disable_regs_two_three

// File: rtl/pmd_cfg.svh
// Offsets, field positions and reset values of the peripheral disable registers.
`ifndef PMD_CFG_SVH
`define PMD_CFG_SVH
`define CC_DISABLE_ADDR     4'h0
`define CI_DISABLE_ADDR     4'h1
`define CC_CAPTURE_LSB      8
`define CC_COMPARE_LSB      0
`define CC_IMPL_MASK        16'h0F0F
`define CI_COMPARATOR_BIT   10
`define CI_I2C2_BIT         1
`define CI_IMPL_MASK        16'h0402
`define DISABLE_RESET       16'h0000
`endif

// File: rtl/pmd_pkg.sv
// Types shared by the peripheral disable register bank.
package pmd_pkg;
  // Register bus request carried as one unit.
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;
  // Per-peripheral gating controls, one bit per unit.
  typedef struct packed {
    logic [3:0] capture_off;
    logic [3:0] compare_off;
    logic       comparator_group_off;
    logic       second_i2c_off;
  } periph_off_type;
endpackage : pmd_pkg

// File: tb/peripheral_disable_regs_two_three_bench.sv
// Self-checking bench for the peripheral disable register bank.
`timescale 1ns/1ps
module peripheral_disable_regs_two_three_bench;
  logic                    clock;
  logic                    nrst;
  pmd_pkg::bus_req_type    req;
  logic [15:0]             rdata;
  pmd_pkg::periph_off_type periph_off;
  logic [9:0]              clk_en;
  logic [9:0]              rst_n;
  int                      fails = 0;
  int                      cmp_count = 0;
  int                      cycles = 0;
  int                      m [2];
  // Device under test.
  peripheral_disable_regs_two_three i_dut (.clock(clock), .nrst(nrst), .bus_req(req),
    .rdata(rdata), .periph_off(periph_off), .periph_clk_en(clk_en), .periph_rst_n(rst_n));
  // Free-running 25 MHz clock.
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // The run needs a few hundred cycles, so 2000 means a hang.
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      fails = fails + 1;
      give_verdict();
    end
  end
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task check_outputs;
    logic [9:0] off;
    off = {m[0][11:8], m[0][3:0], m[1][10], m[1][1]};
    check("periph_off", {6'h00, periph_off}, {6'h00, off});
    check("clk_en", {6'h00, clk_en}, {6'h00, ~off});
    check("rst_n", {6'h00, rst_n}, {6'h00, ~off});
  endtask : check_outputs
  // One access; the strobe is taken at the next edge and read data follow it.
  task op(input logic w, input logic [3:0] a, input logic [15:0] d);
    int exp;
    exp = (a < 2) ? m[a[0]] : 0;
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clock);
    req <= '0;
    if (w && a < 2)
      m[a[0]] = d & (a[0] ? 16'h0402 : 16'h0F0F);
    #1;
    check("rdata", rdata, w ? 16'h0000 : 16'(exp));
    check_outputs();
  endtask : op
  // Write then read the same index with no idle cycle between the strobes.
  task wr_rd(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    if (a < 2)
      m[a[0]] = d & (a[0] ? 16'h0402 : 16'h0F0F);
    @(posedge clock);
    req <= '0;
    #1;
    check("rdata", rdata, (a < 2) ? 16'(m[a[0]]) : 16'h0000);
    @(posedge clock);
    #1;
    check("rdata", rdata, 16'h0000);
    check_outputs();
  endtask : wr_rd
  task do_reset;
    @(posedge clock);
    nrst <= 1'b0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    m[0] = 0;
    m[1] = 0;
    #1;
    check("rdata", rdata, 16'h0000);
    check_outputs();
  endtask : do_reset
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // Main sequence: reset, all-ones writes, random traffic, back-to-back write/read pairs, second reset.
  initial
  begin
    nrst = 1'b0;
    req = '0;
    void'($urandom(32'h23FE));
    do_reset();
    $display("test reset done");
    for (int a = 0; a < 4; a++)
    begin
      op(1'b1, 4'(a), 16'hFFFF);
      op(1'b0, 4'(a), 16'h0000);
    end
    $display("test all ones done");
    repeat (80) op(1'($urandom_range(1)), 4'($urandom_range(3)), 16'($urandom));
    $display("test random done");
    repeat (20) wr_rd(4'($urandom_range(3)), 16'($urandom));
    $display("test back to back done");
    do_reset();
    op(1'b0, 4'h0, 16'h0000);
    op(1'b0, 4'h1, 16'h0000);
    $display("test second reset done");
    give_verdict();
  end
endmodule : peripheral_disable_regs_two_three_bench
